// >>> charger_tracking_pkg.sv
// constants for the charger control registers and solar tracking sequencer
// assumes a 100 MHz system clock and a one-millisecond tick for long timers
// What this block does
// R1: bit 0 at offset 0x13 enables forward input overcurrent protection, resets to 1, and is restored only by register reset.
// R2: while ship_switch_fitted is 0 the battery overcurrent enable, force-off and ship drive control are held at 0.
// R3: software sets ship_switch_fitted when a ship switch is fitted; then the battery overcurrent bit is writable and force-off and drive follow requests.
// R4: bits 4-3 pick the otg discharge limit 3A/4A/5A/off, default 5A, restored by watchdog or register reset.
// R5: bit 2 enables the internal input current limit, default 1, restored by watchdog or register reset.
// R6: bit 1 enables the external limit pin current limit, default 1, restored only by register reset.
// R7: bit 0 enables battery discharge overcurrent protection, default 0, cleared by watchdog or register reset.
// R8: after each measurement the voltage limit becomes the open-circuit voltage times (9+code)/16, default code 5.
// R9: the settle delay before the sample is 50ms, 300ms, 2s or 5s, default 300ms.
// R10: the period between measurements is 30s, 2min, 10min or 30min, default 2min.
// R11: bit 0 of the tracking register enables measurement, default 0, and the register resets only by register reset.
// R12: a measurement halts switching, samples the input with no current, then writes the new voltage limit.
// R13: while enabled a period timer runs and each expiry starts halt, delay, measure, update, then resumes and restarts.
// R14: reserved bit 6 of charger_control_five reads zero and ignores writes.
package charger_tracking_pkg;
  localparam logic [7:0] charger_control_four_addr   = 8'h13;
  localparam logic [7:0] charger_control_five_addr   = 8'h14;
  localparam logic [7:0] solar_tracking_control_addr = 8'h15;

  localparam logic [7:0] charger_control_four_reset   = 8'h01;
  localparam logic [7:0] charger_control_five_reset   = 8'h16;
  localparam logic [7:0] solar_tracking_control_reset = 8'haa;

  // charger_control_five fields
  localparam int fitted_bit      = 7;
  localparam int reserved_bit    = 6;
  localparam int otg_batt_en_bit = 5;
  localparam int otg_limit_hi    = 4;
  localparam int otg_limit_lo    = 3;
  localparam int int_limit_bit   = 2;
  localparam int ext_limit_bit   = 1;
  localparam int batoc_bit       = 0;

  // solar_tracking_control fields
  localparam int scale_hi  = 7;
  localparam int scale_lo  = 5;
  localparam int settle_hi = 4;
  localparam int settle_lo = 3;
  localparam int period_hi = 2;
  localparam int period_lo = 1;
  localparam int track_bit = 0;

  localparam int fwd_ocp_bit = 0;

  // scale is (scale_base + code) sixteenths
  localparam int scale_base  = 9;
  localparam int scale_shift = 4;

  localparam int clk_mhz       = 100;
  localparam int tick_us       = 1000;
  localparam int tick_cycles   = tick_us * clk_mhz;

  localparam int ms_width = 21;
  localparam logic [ms_width-1:0] settle_ms_0 = 21'h00_0032; // 50 ms
  localparam logic [ms_width-1:0] settle_ms_1 = 21'h00_012c; // 300 ms
  localparam logic [ms_width-1:0] settle_ms_2 = 21'h00_07d0; // 2 s
  localparam logic [ms_width-1:0] settle_ms_3 = 21'h00_1388; // 5 s
  localparam logic [ms_width-1:0] period_ms_0 = 21'h00_7530; // 30 s
  localparam logic [ms_width-1:0] period_ms_1 = 21'h01_d4c0; // 2 min
  localparam logic [ms_width-1:0] period_ms_2 = 21'h09_27c0; // 10 min
  localparam logic [ms_width-1:0] period_ms_3 = 21'h1b_7740; // 30 min

  typedef enum logic [1:0] {
    st_wait   = 2'b00,
    st_settle = 2'b01,
    st_sample = 2'b10,
    st_update = 2'b11
  } track_state_t;
endpackage

// >>> ms_tick_gen.sv
// one-cycle pulse every tick_len clock cycles
// assumes a synchronous reset copy from the top module
`timescale 1ns/1ns
`default_nettype none
module ms_tick_gen #(
  parameter int tick_len = 100000
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic restart,
  output logic      tick
);
  logic [31:0] cnt_reg;
  wire         at_end = (cnt_reg == 32'(tick_len - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 32'h0000_0000;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= (restart || at_end) ? 32'h0000_0000 : cnt_reg + 32'h1;
      tick    <= at_end && !restart;
    end
  end
endmodule // ms_tick_gen
`default_nettype wire

// >>> charger_mppt_control_regs.sv
// control registers 0x13..0x15 and the open-circuit tracking sequencer
// assumes the serial host interface decodes transactions into single-cycle
// register strobes on clk; watchdog, register reset and adc sit on clk too
`timescale 1ns/1ns
`default_nettype none
module charger_mppt_control_regs
  import charger_tracking_pkg::*;
#(
  parameter int tick_len = tick_cycles,
  parameter int voc_w    = 16
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  input  wire logic             reg_reset_cmd,
  input  wire logic             watchdog_expire,
  input  wire logic             ship_force_off_req,
  input  wire logic [1:0]       ship_drive_req,
  input  wire logic             adc_done,
  input  wire logic [voc_w-1:0] adc_voc,
  output logic                  forward_input_overcurrent_enable,
  output logic                  ship_switch_fitted,
  output logic                  ship_switch_force_off,
  output logic      [1:0]       ship_drive_control,
  output logic                  otg_battery_limit_enable,
  output logic      [1:0]       otg_discharge_current_limit,
  output logic                  internal_input_current_limit_enable,
  output logic                  external_current_limit_enable,
  output logic                  battery_overcurrent_enable,
  output logic                  solar_tracking_enable,
  output logic                  converter_halt,
  output logic                  adc_sample_req,
  output logic      [voc_w-1:0] input_voltage_limit,
  output logic                  input_voltage_limit_write
);

  // ---------------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------------
  // asynchronous entry, synchronous exit: every flop leaves reset on the
  // same edge, so no register starts a cycle ahead of its neighbours
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------------
  logic [7:0] ctl4_reg;
  logic [7:0] ctl5_reg;
  logic [7:0] track_reg;
  logic [7:0] ctl4_next;
  logic [7:0] ctl5_next;
  logic [7:0] track_next;
  logic [7:0] ctl5_wd;

  wire wr_ctl4  = reg_wr && (reg_addr == charger_control_four_addr);
  wire wr_ctl5  = reg_wr && (reg_addr == charger_control_five_addr);
  wire wr_track = reg_wr && (reg_addr == solar_tracking_control_addr);

  // register reset keeps the fitted bit: only software knows the board
  wire [7:0] ctl5_rr = {ctl5_reg[fitted_bit],
                        charger_control_five_reset[6:0]};

  // ---------------------------------------------------------------------
  // next register values
  // ---------------------------------------------------------------------

  // watchdog leaves fitted, otg enable and external limit alone
  always_comb begin
    ctl5_wd = ctl5_reg;
    ctl5_wd[otg_limit_hi:otg_limit_lo] =
      charger_control_five_reset[otg_limit_hi:otg_limit_lo]; // see R4
    ctl5_wd[int_limit_bit] = charger_control_five_reset[int_limit_bit]; // see R5
    ctl5_wd[batoc_bit]     = 1'b0; // see R7
  end

  always_comb begin
    ctl4_next  = ctl4_reg;
    ctl5_next  = ctl5_reg;
    track_next = track_reg;
    if (reg_reset_cmd) begin
      ctl4_next = charger_control_four_reset; // see R1
      ctl5_next = ctl5_rr; // see R4 see R5 see R6
      track_next = solar_tracking_control_reset; // see R11
    end else begin
      if (watchdog_expire) begin
        ctl5_next = ctl5_wd;
      end
      if (wr_ctl4) begin
        ctl4_next = {7'h00, reg_wdata[fwd_ocp_bit]}; // see R1
      end
      if (wr_ctl5) begin
        ctl5_next = reg_wdata;
      end
      if (wr_track) begin
        track_next = reg_wdata;
      end
    end
    ctl5_next[reserved_bit] = 1'b0; // see R14
    // an unfitted ship switch keeps its dependants at zero
    if (!ctl5_next[fitted_bit]) begin
      ctl5_next[batoc_bit] = 1'b0; // see R2 see R3
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl4_reg  <= charger_control_four_reset;
      ctl5_reg  <= charger_control_five_reset;
      track_reg <= solar_tracking_control_reset;
    end else begin
      ctl4_reg  <= ctl4_next;
      ctl5_reg  <= ctl5_next;
      track_reg <= track_next;
    end
  end

  // ---------------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------------
  // unmapped offsets read zero rather than aliasing a real register
  wire sel_ctl4  = (reg_addr == charger_control_four_addr);
  wire sel_ctl5  = (reg_addr == charger_control_five_addr);
  wire sel_track = (reg_addr == solar_tracking_control_addr);
  wire [7:0] rd_mux =
    sel_ctl4  ? ctl4_reg :
    sel_ctl5  ? ctl5_reg :
    sel_track ? track_reg : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // ---------------------------------------------------------------------
  // control outputs
  // ---------------------------------------------------------------------
  // force-off and drive come from elsewhere; gating them here keeps them
  // quiet even if the requester ignores the fitted bit
  wire       fitted_now     = ctl5_reg[fitted_bit];
  wire       fwd_ocp_next   = ctl4_reg[fwd_ocp_bit]; // see R1
  wire       force_off_next = ship_force_off_req & fitted_now; // see R2
  wire [1:0] drive_next     = ship_drive_req & {2{fitted_now}}; // see R2
  wire       otg_en_next    = ctl5_reg[otg_batt_en_bit];
  wire [1:0] otg_lim_next   = ctl5_reg[otg_limit_hi:otg_limit_lo]; // see R4
  wire       int_lim_next   = ctl5_reg[int_limit_bit]; // see R5
  wire       ext_lim_next   = ctl5_reg[ext_limit_bit]; // see R6
  wire       batoc_next     = ctl5_reg[batoc_bit]; // see R7
  wire       track_en_next  = track_reg[track_bit]; // see R11

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      forward_input_overcurrent_enable    <= 1'b1;
      ship_switch_fitted                  <= 1'b0;
      ship_switch_force_off               <= 1'b0;
      ship_drive_control                  <= 2'h0;
      otg_battery_limit_enable            <= 1'b0;
      otg_discharge_current_limit         <= 2'h2;
      internal_input_current_limit_enable <= 1'b1;
      external_current_limit_enable       <= 1'b1;
      battery_overcurrent_enable          <= 1'b0;
      solar_tracking_enable               <= 1'b0;
    end else begin
      forward_input_overcurrent_enable    <= fwd_ocp_next;
      ship_switch_fitted                  <= fitted_now;
      ship_switch_force_off               <= force_off_next;
      ship_drive_control                  <= drive_next;
      otg_battery_limit_enable            <= otg_en_next;
      otg_discharge_current_limit         <= otg_lim_next;
      internal_input_current_limit_enable <= int_lim_next;
      external_current_limit_enable       <= ext_lim_next;
      battery_overcurrent_enable          <= batoc_next;
      solar_tracking_enable               <= track_en_next;
    end
  end

  // ---------------------------------------------------------------------
  // tracking sequencer
  // ---------------------------------------------------------------------
  function automatic logic [ms_width-1:0] pick_ms(
    input logic [1:0] code,
    input logic       is_period
  );
    logic [ms_width-1:0] ms;
    ms = settle_ms_0;
    case ({is_period, code})
      3'b000:  ms = settle_ms_0;
      3'b001:  ms = settle_ms_1;
      3'b010:  ms = settle_ms_2;
      3'b011:  ms = settle_ms_3;
      3'b100:  ms = period_ms_0;
      3'b101:  ms = period_ms_1;
      3'b110:  ms = period_ms_2;
      default: ms = period_ms_3;
    endcase
    return ms;
  endfunction

  track_state_t        state_reg;
  track_state_t        state_next;
  logic [ms_width-1:0] ms_cnt_reg;
  logic [voc_w-1:0]    voc_reg;
  logic                tick;

  wire track_on = track_reg[track_bit] && !reg_reset_cmd;
  wire [ms_width-1:0] settle_len =
    pick_ms(track_reg[settle_hi:settle_lo], 1'b0); // see R9
  wire [ms_width-1:0] period_len =
    pick_ms(track_reg[period_hi:period_lo], 1'b1); // see R10
  wire [ms_width-1:0] ms_target = (state_reg == st_wait) ? period_len
                                                         : settle_len;
  wire timer_done = tick && (ms_cnt_reg + 21'h1 >= ms_target);
  wire state_change = (state_next != state_reg);

  // ---------------------------------------------------------------------
  // limit arithmetic
  // ---------------------------------------------------------------------
  // (voc * (9 + code)) >> 4, kept at adc width; code 7 gives unity, so
  // the top bit of the product is never needed
  wire [4:0] scale_num = 5'(scale_base) + {2'b00, track_reg[scale_hi:scale_lo]};
  wire [voc_w+4:0] scaled_full = voc_reg * scale_num; // see R8
  wire [voc_w-1:0] scaled = scaled_full[voc_w+3:scale_shift];

  always_comb begin
    state_next = state_reg;
    if (!track_on) begin
      state_next = st_wait;
    end else begin
      case (state_reg)
        st_wait:   if (timer_done) state_next = st_settle; // see R13
        st_settle: if (timer_done) state_next = st_sample; // see R12
        st_sample: if (adc_done)   state_next = st_update; // see R12
        st_update: state_next = st_wait; // see R13
        default:   state_next = st_wait;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // tracking timer
  // ---------------------------------------------------------------------
  // the tick restarts with every state change so each phase counts whole
  // ticks; a phase runs exactly one clock cycle longer than asked
  ms_tick_gen #(
    .tick_len (tick_len)
  ) u_tick (
    .clk     (clk),
    .rst_n   (rst_n),
    .restart (state_change || !track_on),
    .tick    (tick)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= st_wait;
      ms_cnt_reg <= 21'h0;
      voc_reg    <= '0;
    end else begin
      state_reg <= state_next;
      if (state_change || !track_on) begin
        ms_cnt_reg <= 21'h0; // see R13
      end else if (tick) begin
        ms_cnt_reg <= ms_cnt_reg + 21'h1;
      end
      if (state_reg == st_sample && adc_done) begin
        voc_reg <= adc_voc;
      end
    end
  end

  // ---------------------------------------------------------------------
  // sequencer outputs
  // ---------------------------------------------------------------------
  // halt follows the next state so switching stops on the edge the settle
  // timer starts; a cut measurement drops its write pulse
  wire halt_next   = (state_next != st_wait); // see R12
  wire sample_next = (state_reg == st_settle) && (state_next == st_sample);
  wire update_now  = (state_reg == st_update) && track_on; // see R8

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_halt            <= 1'b0;
      adc_sample_req            <= 1'b0;
      input_voltage_limit       <= '0;
      input_voltage_limit_write <= 1'b0;
    end else begin
      // switching stays off from settle until the limit write, which rises as halt drops
      converter_halt <= halt_next; // see R12
      adc_sample_req <= sample_next; // see R12
      input_voltage_limit_write <= update_now;
      if (update_now) begin
        input_voltage_limit <= scaled; // see R8
      end
    end
  end
endmodule // charger_mppt_control_regs
`default_nettype wire

// >>> charger_mppt_control_regs_asserts.sv
// assertions for the charger control registers and tracking sequencer
// assumes binding onto charger_mppt_control_regs, all on one clock
`timescale 1ns/1ns
`default_nettype none
module charger_mppt_control_regs_asserts (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_reset_cmd,
  input wire logic       watchdog_expire,
  input wire logic       adc_done,
  input wire logic       forward_input_overcurrent_enable,
  input wire logic       ship_switch_fitted,
  input wire logic       ship_switch_force_off,
  input wire logic [1:0] ship_drive_control,
  input wire logic [1:0] otg_discharge_current_limit,
  input wire logic       internal_input_current_limit_enable,
  input wire logic       external_current_limit_enable,
  input wire logic       battery_overcurrent_enable,
  input wire logic       solar_tracking_enable,
  input wire logic       converter_halt,
  input wire logic       adc_sample_req,
  input wire logic       input_voltage_limit_write
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  lock_held_a: assert property (
    !ship_switch_fitted |-> !battery_overcurrent_enable &&
    !ship_switch_force_off && ship_drive_control == 2'b00)
    else $error("ship bits set while no ship switch fitted");
  wd_defaults_a: assert property (
    watchdog_expire && !reg_reset_cmd && !reg_wr |-> ##2
    otg_discharge_current_limit == 2'b10 &&
    internal_input_current_limit_enable && !battery_overcurrent_enable)
    else $error("watchdog did not restore its fields");
  wd_keeps_a: assert property (
    watchdog_expire && !reg_reset_cmd && !reg_wr |-> ##2
    $stable(external_current_limit_enable) &&
    $stable(forward_input_overcurrent_enable) &&
    $stable(solar_tracking_enable))
    else $error("watchdog touched a register-reset-only field");
  rr_defaults_a: assert property (
    reg_reset_cmd |-> ##2 forward_input_overcurrent_enable &&
    external_current_limit_enable && internal_input_current_limit_enable &&
    otg_discharge_current_limit == 2'b10 && !battery_overcurrent_enable &&
    !solar_tracking_enable)
    else $error("register reset left a field off its default");
  rsvd_zero_a: assert property (
    reg_rd && reg_addr == 8'h14 |=> !reg_rdata[6])
    else $error("reserved bit read as one");
  unmapped_zero_a: assert property (
    reg_rd && reg_addr > 8'h15 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  sample_in_halt_a: assert property (
    adc_sample_req |-> converter_halt ##1 !adc_sample_req)
    else $error("sample request outside halt or too long");
  write_end_a: assert property (
    input_voltage_limit_write |-> !converter_halt &&
    $past(converter_halt) && $past(adc_done, 2))
    else $error("limit write not tied to sample and halt end");
  halt_enabled_a: assert property (
    $rose(converter_halt) |-> solar_tracking_enable)
    else $error("measurement started while tracking disabled");
endmodule // charger_mppt_control_regs_asserts
bind charger_mppt_control_regs charger_mppt_control_regs_asserts u_chk (
  .clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_rdata, .reg_reset_cmd,
  .watchdog_expire, .adc_done, .forward_input_overcurrent_enable,
  .ship_switch_fitted, .ship_switch_force_off, .ship_drive_control,
  .otg_discharge_current_limit, .internal_input_current_limit_enable,
  .external_current_limit_enable, .battery_overcurrent_enable,
  .solar_tracking_enable, .converter_halt, .adc_sample_req,
  .input_voltage_limit_write);
`default_nettype wire

// >>> tb_charger_mppt_control_regs.sv
// self-checking bench for the charger control registers
// assumes a short ms tick (2 cycles) so a 30 s period fits the run
`timescale 1ns/1ns
`default_nettype none
module tb_charger_mppt_control_regs;
  logic        clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        reg_reset_cmd = 1'b0, watchdog_expire = 1'b0;
  logic        ship_force_off_req = 1'b1, adc_done = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0]  ship_drive_req = 2'b11, drv, otg;
  logic [15:0] adc_voc = 16'h1000, ivl;
  logic        fwd, fit, fof, otge, inten, exten, batoc, trk, halt, sreq, ivw;
  int          bad_count = 0, total_checks = 0, n;

  always #5 clk = ~clk;

  charger_mppt_control_regs #(.tick_len(2), .voc_w(16)) DUT (
    .clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_reset_cmd, .watchdog_expire, .ship_force_off_req, .ship_drive_req,
    .adc_done, .adc_voc, .forward_input_overcurrent_enable(fwd),
    .ship_switch_fitted(fit), .ship_switch_force_off(fof),
    .ship_drive_control(drv), .otg_battery_limit_enable(otge),
    .otg_discharge_current_limit(otg),
    .internal_input_current_limit_enable(inten),
    .external_current_limit_enable(exten),
    .battery_overcurrent_enable(batoc), .solar_tracking_enable(trk),
    .converter_halt(halt), .adc_sample_req(sreq),
    .input_voltage_limit(ivl), .input_voltage_limit_write(ivw));

  // --------------------------------------------------------------------
  // access tasks
  // --------------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e, input string nm);
    @(posedge clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    chk(nm, {8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    #1 resetn = 1'b1;
    idle(5);
    rd(8'h13, 8'h01, "ctl4 reset");
    rd(8'h14, 8'h16, "ctl5 reset");
    rd(8'h15, 8'haa, "track reset");
    rd(8'h40, 8'h00, "unmapped read");
    wr(8'h14, 8'h7f);
    rd(8'h14, 8'h3e, "ctl5 locked");
    idle(2);
    chk("locked outputs", 16'({fof, drv, batoc}), 16'h0000);
    wr(8'h14, 8'h81);
    rd(8'h14, 8'h81, "ctl5 fitted");
    idle(2);
    chk("unlocked outputs", 16'({fit, fof, drv, batoc}), 16'h001f);
    for (n = 0; n < 4; n++) begin
      wr(8'h14, 8'h80 | 8'(n << 3));
      idle(2);
      chk("otg limit", 16'(otg), 16'(n));
    end
    // non-default values everywhere so the watchdog's reach is visible
    wr(8'h14, 8'he1);
    wr(8'h13, 8'h00);
    wr(8'h15, 8'h55);
    rd(8'h14, 8'ha1, "reserved bit");
    @(posedge clk);
    #1 watchdog_expire = 1'b1;
    @(posedge clk);
    #1 watchdog_expire = 1'b0;
    rd(8'h14, 8'hb4, "ctl5 after watchdog");
    chk("otg enable kept", 16'(otge), 16'h0001);
    rd(8'h13, 8'h00, "ctl4 after watchdog");
    rd(8'h15, 8'h55, "track after watchdog");
    @(posedge clk);
    #1 reg_reset_cmd = 1'b1;
    @(posedge clk);
    #1 reg_reset_cmd = 1'b0;
    rd(8'h13, 8'h01, "ctl4 after reg reset");
    rd(8'h14, 8'h96, "ctl5 after reg reset");
    rd(8'h15, 8'haa, "track after reg reset");
    chk("enables after reg reset", 16'({fwd, inten, exten}), 16'h0007);
    // scale code 3, 50 ms settle, 30 s period, tracking on
    wr(8'h15, 8'h61);
    n = 0;
    while (halt !== 1'b1 && n < 61000) begin
      @(posedge clk);
      #1 n++;
    end
    chk("period cycles", 16'(n > 59990 && n < 60010), 16'h0001);
    n = 0;
    while (sreq !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    chk("settle cycles", 16'(n > 96 && n < 104), 16'h0001);
    chk("halt in sample", 16'(halt), 16'h0001);
    adc_done = 1'b1;
    @(posedge clk);
    #1 adc_done = 1'b0;
    idle(1);
    chk("limit write", 16'({ivw, halt}), 16'h0002);
    chk("limit value", ivl, 16'h0c00);
    idle(3);
    close_out();
  end

  initial begin
    #700000;
    bad_count++;
    close_out();
  end
endmodule // tb_charger_mppt_control_regs
`default_nettype wire
